// file: hw/msgm_defs.svh
`ifndef MSGM_DEFS_SVH
`define MSGM_DEFS_SVH

// register byte addresses
`define MSGM_ADDR_PART_ID 8'h13
`define MSGM_ADDR_MODE_STATUS 8'h14

// operating mode field encodings
`define MSGM_MODE_STANDBY 2'h0
`define MSGM_MODE_FAST 2'h1
`define MSGM_MODE_SLOW 2'h2
`define MSGM_MODE_TRIG 2'h3
`define MSGM_MODE_W 2

// status register field positions
`define MSGM_ERR_BIT 7
`define MSGM_CNT_HI 6
`define MSGM_CNT_LO 2
`define MSGM_CNT_W 5
`define MSGM_BUF_CNT_W 6

// buffer mode value that disables the buffer
`define MSGM_BUF_MODE_OFF 2'h0

// reset values and count saturation limit
`define MSGM_RDATA_RST 8'h00
`define MSGM_CNT_RST 5'h00
`define MSGM_CNT_MAX 5'h1f

// cycles after reset release before the strap is trusted
`define MSGM_BOOT_SETTLE 2'h3

`endif

// file: hw/msgm_pkg.sv
package msgm_pkg;
   // gray codes along standby, trigger wait, trigger measure, fast, slow
   typedef enum logic [2:0] {
      ST_STANDBY = 3'h0,
      ST_TRIG_WAIT = 3'h1,
      ST_TRIG_MEAS = 3'h3,
      ST_FAST = 3'h2,
      ST_SLOW = 3'h6
   } op_state_e;

   typedef logic [1:0] op_mode_t;
endpackage

// file: hw/gate_if.sv
`timescale 1ns/1ps
`include "msgm_defs.svh"

interface gate_if;
   logic gate_en;
   logic sample_tick;
   logic odr_tick;
   logic buf_read;
   logic [`MSGM_BUF_CNT_W-1:0] buf_cnt;
   logic buf_flush;
   logic buf_mode_wr;
   logic [1:0] buf_mode_wdata;
   logic stb_to_act;
   logic soft_rst;
   logic err;
   logic [`MSGM_CNT_W-1:0] cnt;
   logic discard;

   modport mon (
      input gate_en, sample_tick, odr_tick, buf_read, buf_cnt, buf_flush,
      input buf_mode_wr, buf_mode_wdata, stb_to_act, soft_rst,
      output err, cnt, discard
   );
   modport ctl (
      output gate_en, sample_tick, odr_tick, buf_read, buf_cnt, buf_flush,
      output buf_mode_wr, buf_mode_wdata, stb_to_act, soft_rst,
      input err, cnt, discard
   );
endinterface

// file: hw/gate_monitor.sv
`timescale 1ns/1ps
`include "msgm_defs.svh"

module gate_monitor
   import msgm_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst,
   gate_if.mon g
);
   logic err_q;
   logic [`MSGM_CNT_W-1:0] cnt_q;
   logic discard_q;
   logic set_err;
   logic mode_off;
   logic clr;

   // ****************************************
   // clear and set conditions
   // ****************************************
   assign mode_off = g.buf_mode_wr &&
      (g.buf_mode_wdata == `MSGM_BUF_MODE_OFF);
   // overrun: sample arrives while buffer still holds data
   assign set_err = g.gate_en && g.sample_tick &&
      (g.buf_cnt != '0);
   // drained by reads, flush, disable, standby to active, soft reset
   assign clr = (g.buf_read && (g.buf_cnt == '0)) || g.buf_flush ||
      mode_off || g.stb_to_act || g.soft_rst;

   // ****************************************
   // gate error flag
   // ****************************************
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         err_q <= 1'b0;
      end else if (set_err) begin
         err_q <= 1'b1;
      end else if (clr) begin
         err_q <= 1'b0;
      end else if (g.buf_cnt == '0) begin
         err_q <= 1'b0;
      end
   end

   // ****************************************
   // elapsed period count
   // ****************************************
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         cnt_q <= `MSGM_CNT_RST;
      end else if (set_err && !err_q) begin
         cnt_q <= `MSGM_CNT_RST;
      end else if (clr || !err_q) begin
         cnt_q <= `MSGM_CNT_RST;
      end else if (g.odr_tick && (cnt_q != `MSGM_CNT_MAX)) begin
         cnt_q <= cnt_q + 5'h01;
      end
   end

   // ****************************************
   // buffer content discard on disable
   // ****************************************
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         discard_q <= 1'b0;
      end else begin
         discard_q <= mode_off;
      end
   end

   assign g.err = err_q;
   assign g.cnt = cnt_q;
   assign g.discard = discard_q;
endmodule

// file: hw/mode_status_gate_monitor.sv
`timescale 1ns/1ps
`include "msgm_defs.svh"

module mode_status_gate_monitor
   import msgm_pkg::*;
#(
   parameter logic [7:0] PART_ID = 8'h5a // arbitrary value
)
(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_boot_strap_pin,
   input wire logic i_soft_reset,
   input wire logic i_motion_detection_enable,
   input wire logic i_active,
   input wire logic i_auto_sleep,
   input wire logic i_auto_wake,
   input wire logic i_second_irq_pin_trigger_select,
   input wire logic i_trigger_pin,
   input wire logic i_meas_done,
   input wire logic i_motion_state_out_enable,
   input wire logic i_motion_state_pin_select,
   input wire logic i_irq_polarity,
   input wire logic i_gate_enable,
   input wire logic i_sample_tick,
   input wire logic i_odr_tick,
   input wire logic i_buf_read,
   input wire logic [`MSGM_BUF_CNT_W-1:0] i_buf_count,
   input wire logic i_buf_flush,
   input wire logic i_buf_mode_wr,
   input wire logic [1:0] i_buf_mode_wdata,
   input wire logic [7:0] i_reg_addr,
   input wire logic i_reg_rd,
   input wire logic i_reg_wr,
   input wire logic [7:0] i_reg_wdata,
   output logic [7:0] o_reg_rdata,
   output logic o_reg_rvalid,
   output logic o_debounce_reset_orientation_function,
   output logic o_debounce_reset_change_within,
   output logic o_debounce_reset_change_outside,
   output logic o_first_irq_pin_oe,
   output logic o_first_irq_pin_out,
   output logic o_second_irq_pin_oe,
   output logic o_second_irq_pin_out,
   output logic o_buf_discard
);
   // ****************************************
   // mode field of a state
   // ****************************************
   function automatic op_mode_t mode_of(input op_state_e s);
      mode_of = `MSGM_MODE_STANDBY;
      unique case (s)
         ST_STANDBY: mode_of = `MSGM_MODE_STANDBY;
         ST_FAST: mode_of = `MSGM_MODE_FAST;
         ST_SLOW: mode_of = `MSGM_MODE_SLOW;
         ST_TRIG_WAIT: mode_of = `MSGM_MODE_TRIG;
         ST_TRIG_MEAS: mode_of = `MSGM_MODE_FAST;
         default: mode_of = `MSGM_MODE_STANDBY;
      endcase
   endfunction

   op_state_e state_q;
   op_state_e state_d;
   logic [2:0] strap_sync_q;
   logic strap_q;
   logic strap_d;
   logic [2:0] trig_sync_q;
   logic trig_lvl_q;
   logic trig_edge;
   logic boot_q;
   logic [1:0] settle_q;
   logic dbr_d;
   logic dbr_q;
   logic trig_ok;
   logic stb_to_act;
   logic motion_drive;

   gate_if g ();

   // ****************************************
   // pin synchronisers
   // ****************************************
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         strap_sync_q <= 3'h0;
         strap_q <= 1'b0;
      end else begin
         strap_sync_q <= {strap_sync_q[1:0], i_boot_strap_pin};
         strap_q <= strap_d;
      end
   end

   assign strap_d = (strap_sync_q[1] == strap_sync_q[2]) ?
      strap_sync_q[2] : strap_q;

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         trig_sync_q <= 3'h0;
         trig_lvl_q <= 1'b0;
      end else begin
         trig_sync_q <= {trig_sync_q[1:0], i_trigger_pin};
         if (trig_sync_q[1] == trig_sync_q[2]) begin
            trig_lvl_q <= trig_sync_q[2];
         end
      end
   end

   assign trig_edge = (trig_sync_q[1] == trig_sync_q[2]) &&
      trig_sync_q[2] && !trig_lvl_q;

   // ****************************************
   // boot sequencing
   // ****************************************
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         boot_q <= 1'b1;
         settle_q <= 2'h0;
      end else if (i_soft_reset) begin
         boot_q <= 1'b1;
         settle_q <= 2'h0;
      end else if (boot_q) begin
         if (settle_q == `MSGM_BOOT_SETTLE) begin
            boot_q <= 1'b0;
         end else begin
            settle_q <= settle_q + 2'h1;
         end
      end
   end

   // ****************************************
   // operating mode sequencing
   // ****************************************
   assign trig_ok = i_second_irq_pin_trigger_select && !strap_q;

   always_comb begin
      state_d = state_q;
      if (boot_q || i_soft_reset) begin
         state_d = ST_STANDBY;
         if (!i_soft_reset && (settle_q == `MSGM_BOOT_SETTLE)) begin
            state_d = (strap_d && i_motion_detection_enable) ?
               ST_FAST : ST_STANDBY;
         end
      end else if (!i_active) begin
         state_d = ST_STANDBY;
      end else begin
         unique case (state_q)
            ST_STANDBY: begin
               state_d = trig_ok ? ST_TRIG_WAIT : ST_FAST;
            end
            ST_FAST: begin
               if (trig_ok) begin
                  state_d = ST_TRIG_WAIT;
               end else if (i_auto_sleep) begin
                  state_d = ST_SLOW;
               end
            end
            ST_SLOW: begin
               if (trig_ok) begin
                  state_d = ST_TRIG_WAIT;
               end else if (i_auto_wake) begin
                  state_d = ST_FAST;
               end
            end
            ST_TRIG_WAIT: begin
               if (!trig_ok) begin
                  state_d = ST_FAST;
               end else if (trig_edge) begin
                  state_d = ST_TRIG_MEAS;
               end
            end
            ST_TRIG_MEAS: begin
               if (i_meas_done) begin
                  state_d = trig_ok ? ST_TRIG_WAIT : ST_FAST;
               end
            end
         endcase
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         state_q <= ST_STANDBY;
      end else begin
         state_q <= state_d;
      end
   end

   // ****************************************
   // debounce reset on mode entry
   // ****************************************
   assign dbr_d = (mode_of(state_d) != mode_of(state_q)) &&
      (mode_of(state_d) != `MSGM_MODE_STANDBY);

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         dbr_q <= 1'b0;
      end else begin
         dbr_q <= dbr_d;
      end
   end

   assign o_debounce_reset_orientation_function = dbr_q;
   assign o_debounce_reset_change_within = dbr_q;
   assign o_debounce_reset_change_outside = dbr_q;

   // ****************************************
   // motion state pin output
   // ****************************************
   assign motion_drive = i_motion_state_out_enable &&
      (mode_of(state_q) == `MSGM_MODE_FAST);

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_first_irq_pin_oe <= 1'b0;
         o_first_irq_pin_out <= 1'b0;
         o_second_irq_pin_oe <= 1'b0;
         o_second_irq_pin_out <= 1'b0;
      end else begin
         o_first_irq_pin_oe <= motion_drive &&
            !i_motion_state_pin_select;
         o_first_irq_pin_out <= i_irq_polarity;
         o_second_irq_pin_oe <= motion_drive && i_motion_state_pin_select &&
            !i_second_irq_pin_trigger_select;
         o_second_irq_pin_out <= i_irq_polarity;
      end
   end

   // ****************************************
   // buffer gate monitor
   // ****************************************
   assign stb_to_act = !boot_q && (state_q == ST_STANDBY) &&
      (state_d != ST_STANDBY);

   assign g.gate_en = i_gate_enable;
   assign g.sample_tick = i_sample_tick;
   assign g.odr_tick = i_odr_tick;
   assign g.buf_read = i_buf_read;
   assign g.buf_cnt = i_buf_count;
   assign g.buf_flush = i_buf_flush;
   assign g.buf_mode_wr = i_buf_mode_wr;
   assign g.buf_mode_wdata = i_buf_mode_wdata;
   assign g.stb_to_act = stb_to_act;
   assign g.soft_rst = i_soft_reset;
   assign o_buf_discard = g.discard;

   gate_monitor u_gate (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .g(g.mon)
   );

   // ****************************************
   // register read port
   // ****************************************
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_reg_rdata <= `MSGM_RDATA_RST;
         o_reg_rvalid <= 1'b0;
      end else begin
         o_reg_rvalid <= i_reg_rd;
         if (i_reg_rd) begin
            unique case (i_reg_addr)
               `MSGM_ADDR_PART_ID: o_reg_rdata <= PART_ID;
               `MSGM_ADDR_MODE_STATUS: begin
                  o_reg_rdata <= {g.err, g.cnt, mode_of(state_q)};
               end
               default: o_reg_rdata <= `MSGM_RDATA_RST;
            endcase
         end
      end
   end

   // writes never reach any state here; port kept for bus symmetry
   logic wr_unused;
   assign wr_unused = i_reg_wr ^ (^i_reg_wdata);
endmodule

// file: verif/msgm_monitor.sv
`timescale 1ns/1ps
`include "msgm_defs.svh"
// ****************
// status port checks
// ****************
module msgm_checker #(
   parameter logic [7:0] PART_ID = 8'h5a // arbitrary value
)(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_boot_strap_pin,
   input wire logic i_second_irq_pin_trigger_select,
   input wire logic i_motion_state_out_enable,
   input wire logic i_motion_state_pin_select,
   input wire logic i_irq_polarity,
   input wire logic i_gate_enable,
   input wire logic i_sample_tick,
   input wire logic [`MSGM_BUF_CNT_W-1:0] i_buf_count,
   input wire logic i_buf_flush,
   input wire logic i_buf_mode_wr,
   input wire logic [1:0] i_buf_mode_wdata,
   input wire logic [7:0] i_reg_addr,
   input wire logic i_reg_rd,
   input wire logic i_reg_wr,
   input wire logic [7:0] o_reg_rdata,
   input wire logic o_reg_rvalid,
   input wire logic o_debounce_reset_orientation_function,
   input wire logic o_debounce_reset_change_within,
   input wire logic o_debounce_reset_change_outside,
   input wire logic o_first_irq_pin_oe,
   input wire logic o_first_irq_pin_out,
   input wire logic o_second_irq_pin_oe,
   input wire logic o_second_irq_pin_out,
   input wire logic o_buf_discard
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_rst);
   part_id_read_a: assert property (i_reg_rd && i_reg_addr == 8'h13 |=>
      o_reg_rvalid && o_reg_rdata == PART_ID) else $error("id read wrong");
   write_ignored_a: assert property (i_reg_wr && !i_reg_rd |=>
      !o_reg_rvalid) else $error("write answered");
   strap_no_trig_a: assert property (o_reg_rvalid &&
      $past(i_reg_addr) == 8'h14 && i_boot_strap_pin &&
      $past(i_boot_strap_pin, 8) |-> o_reg_rdata[1:0] != 2'h3)
      else $error("trigger mode with strap high");
   gate_set_a: assert property (i_gate_enable && i_sample_tick &&
      i_buf_count != 0 ##1 i_reg_rd && i_reg_addr == 8'h14 |=>
      o_reg_rdata[7]) else $error("gate error not set");
   flush_clear_a: assert property (i_buf_flush && !i_sample_tick
      ##1 i_reg_rd && i_reg_addr == 8'h14 |=> o_reg_rdata[7:2] == 6'h00)
      else $error("flush left gate state");
   discard_a: assert property (i_buf_mode_wr &&
      i_buf_mode_wdata == 2'h0 |=> o_buf_discard) else $error("no discard");
   discard_cause_a: assert property (o_buf_discard |->
      $past(i_buf_mode_wr) && $past(i_buf_mode_wdata) == 2'h0)
      else $error("spurious discard");
   debounce_same_a: assert property (o_debounce_reset_orientation_function ==
      o_debounce_reset_change_within && o_debounce_reset_orientation_function ==
      o_debounce_reset_change_outside) else $error("debounce resets differ");
   first_pin_a: assert property (o_first_irq_pin_oe |->
      $past(i_motion_state_out_enable) && !$past(i_motion_state_pin_select)
      && o_first_irq_pin_out == $past(i_irq_polarity))
      else $error("first pin drive wrong");
   second_pin_a: assert property (o_second_irq_pin_oe |->
      $past(i_motion_state_pin_select) &&
      !$past(i_second_irq_pin_trigger_select) &&
      o_second_irq_pin_out == $past(i_irq_polarity))
      else $error("second pin drive wrong");
   status_cnt_a: assert property (i_reg_rd && i_reg_addr == 8'h14 |=>
      o_reg_rvalid && (o_reg_rdata[7] || o_reg_rdata[6:2] == 5'h00))
      else $error("gate count without error");
endmodule
bind mode_status_gate_monitor msgm_checker #(.PART_ID(PART_ID))
   msgm_checker_inst (.*);

// file: verif/host_model.sv
`timescale 1ns/1ps
// ****************
// host register access
// ****************
module host_model (
   input wire logic i_clk,
   output logic [7:0] o_reg_addr,
   output logic o_reg_rd,
   output logic o_reg_wr,
   output logic [7:0] o_reg_wdata
);
   initial begin
      o_reg_addr = 8'h00;
      o_reg_rd = 1'b0;
      o_reg_wr = 1'b0;
      o_reg_wdata = 8'h00;
   end
   // reads the register at address a; idle bus shows the inverted address
   task automatic rd(input logic [7:0] a);
      o_reg_addr = a;
      o_reg_rd = 1'b1;
      @(negedge i_clk);
      o_reg_rd = 1'b0;
      o_reg_addr = ~a;
      @(negedge i_clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      o_reg_addr = a;
      o_reg_wdata = d;
      o_reg_wr = 1'b1;
      @(negedge i_clk);
      o_reg_wr = 1'b0;
      o_reg_addr = ~a;
      o_reg_wdata = ~d;
      @(negedge i_clk);
   endtask
endmodule

// file: verif/testbench.sv
`timescale 1ns/1ps
`include "msgm_defs.svh"
// ****************
// stimulus and checking
// ****************
module testbench;
   localparam logic [7:0] PID = 8'h5a; // arbitrary value
   logic i_clk = 1'b0, i_rst = 1'b1, i_boot_strap_pin = 1'b0;
   logic i_soft_reset = 1'b0, i_motion_detection_enable = 1'b0;
   logic i_active = 1'b0, i_auto_sleep = 1'b0, i_auto_wake = 1'b0;
   logic i_second_irq_pin_trigger_select = 1'b0, i_trigger_pin = 1'b0;
   logic i_meas_done = 1'b0, i_motion_state_out_enable = 1'b0;
   logic i_motion_state_pin_select = 1'b0, i_irq_polarity = 1'b0;
   logic i_gate_enable = 1'b0, i_sample_tick = 1'b0, i_odr_tick = 1'b0;
   logic i_buf_read = 1'b0, i_buf_flush = 1'b0, i_buf_mode_wr = 1'b0;
   logic [1:0] i_buf_mode_wdata = 2'h1;
   logic [`MSGM_BUF_CNT_W-1:0] i_buf_count = 6'h00;
   logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata;
   logic i_reg_rd, i_reg_wr, o_reg_rvalid, o_buf_discard;
   logic o_debounce_reset_orientation_function, o_debounce_reset_change_within;
   logic o_debounce_reset_change_outside, o_first_irq_pin_oe;
   logic o_first_irq_pin_out, o_second_irq_pin_oe, o_second_irq_pin_out;
   logic [7:0] exp_q[$];
   logic [31:0] rs = 32'h3540cea3;
   int err_count = 0, cmp_count = 0, n, dbr_n = 0;
   logic [5:0] c;
   host_model host_model_inst (.i_clk(i_clk), .o_reg_addr(i_reg_addr),
      .o_reg_rd(i_reg_rd), .o_reg_wr(i_reg_wr), .o_reg_wdata(i_reg_wdata));
   mode_status_gate_monitor #(.PART_ID(PID))
      mode_status_gate_monitor_inst (.*);
   always #4 i_clk = ~i_clk;
   function automatic logic [31:0] rnd();
      rs ^= rs << 13;
      rs ^= rs >> 17;
      rs ^= rs << 5;
      return rs;
   endfunction
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic tick(input int k);
      repeat (k) @(negedge i_clk);
   endtask
   task automatic pulse(ref logic s);
      s = 1'b1;
      tick(1);
      s = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      host_model_inst.rd(a);
   endtask
   task automatic finish_test();
      tick(3);
      if (err_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   always @(negedge i_clk) begin
      if (o_reg_rvalid === 1'b1) begin
         if (exp_q.size() == 0) check(o_reg_rdata, 8'hxx);
         else check(o_reg_rdata, exp_q.pop_front());
      end
   end
   always @(negedge i_clk) begin
      dbr_n += o_debounce_reset_orientation_function + o_debounce_reset_change_within +
         o_debounce_reset_change_outside;
   end
   initial begin
      #50000;
      err_count++;
      finish_test();
   end
   initial begin
      tick(12);
      i_rst = 1'b0;
      tick(8);
      rd(8'h13, PID);
      rd(8'h14, 8'h00);
      host_model_inst.wr(8'h13, 8'hff);
      host_model_inst.wr(8'h14, 8'hff);
      rd(8'h13, PID);
      rd(8'h14, 8'h00);
      rd(8'h20, 8'h00);
      i_second_irq_pin_trigger_select = 1'b1;
      i_active = 1'b1;
      tick(3);
      rd(8'h14, 8'h03);
      i_trigger_pin = 1'b1;
      tick(8);
      rd(8'h14, 8'h01);
      i_trigger_pin = 1'b0;
      pulse(i_meas_done);
      tick(1);
      rd(8'h14, 8'h03);
      i_second_irq_pin_trigger_select = 1'b0;
      tick(3);
      rd(8'h14, 8'h01);
      pulse(i_auto_sleep);
      tick(2);
      rd(8'h14, 8'h02);
      pulse(i_auto_wake);
      tick(2);
      rd(8'h14, 8'h01);
      check(8'(dbr_n), 8'h12);
      i_motion_state_out_enable = 1'b1;
      for (int k = 0; k < 4; k++) begin
         {i_motion_state_pin_select, i_irq_polarity} = 2'(k);
         tick(2);
         check({4'h0, o_first_irq_pin_oe, o_first_irq_pin_oe &
            o_first_irq_pin_out, o_second_irq_pin_oe, o_second_irq_pin_oe &
            o_second_irq_pin_out}, {4'h0, !k[1], !k[1] & k[0], k[1],
            k[1] & k[0]});
      end
      i_motion_state_out_enable = 1'b0;
      i_gate_enable = 1'b1;
      for (int k = 0; k < 4; k++) begin
         n = int'(rnd() % 8) + 1;
         c = 6'(rnd() % 63 + 1);
         i_buf_count = c;
         pulse(i_sample_tick);
         rd(8'h14, 8'h81);
         repeat (n) pulse(i_odr_tick);
         rd(8'h14, {1'b1, 5'(n), 2'h1});
         case (k)
            0: begin
               i_buf_count = 6'h00;
               pulse(i_buf_read);
            end
            1: pulse(i_buf_flush);
            2: begin
               i_buf_mode_wdata = 2'h0;
               pulse(i_buf_mode_wr);
               i_buf_mode_wdata = 2'h1;
            end
            default: begin
               i_active = 1'b0;
               tick(3);
               i_active = 1'b1;
               tick(2);
            end
         endcase
         rd(8'h14, 8'h01);
      end
      i_rst = 1'b1;
      i_boot_strap_pin = 1'b1;
      i_motion_detection_enable = 1'b1;
      i_second_irq_pin_trigger_select = 1'b1;
      tick(2);
      i_rst = 1'b0;
      tick(4);
      rd(8'h14, 8'h01);
      pulse(i_soft_reset);
      tick(10);
      rd(8'h14, 8'h01);
      tick(2);
      check(8'(dbr_n), 8'h1b);
      finish_test();
   end
endmodule
